// >>> shared/sesr_pkg.sv
// Purpose: constants for the SPI error status response formatter
// Assumes: 32-bit frames, MSB first, mode 0 style link
// Notes: all offsets, field positions and codes live here
package sesr_pkg;
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned NUM_SRC = 11;
  // Fault source index equals priority number minus one
  localparam int unsigned PRI_SPI = 0;
  localparam int unsigned PRI_MISO = 1;
  localparam int unsigned PRI_RESET = 2;
  localparam int unsigned PRI_SUPPLY = 3;
  localparam int unsigned PRI_TEST = 4;
  localparam int unsigned PRI_FOTP = 5;
  localparam int unsigned PRI_URW = 6;
  localparam int unsigned PRI_UOTP = 7;
  localparam int unsigned PRI_TEMP = 8;
  localparam int unsigned PRI_OFFS = 9;
  localparam int unsigned PRI_OSC = 10;
  // Field positions
  localparam int unsigned CMD_MSB = 31;
  localparam int unsigned ST_LSB = 26;
  localparam int unsigned SD_LSB = 14;
  localparam int unsigned SF_LSB = 8;
  localparam int unsigned RD_LSB = 8;
  // Codes
  localparam logic [1:0] ST_ERROR = 2'h3;
  localparam logic [1:0] SF_GRP_A = 2'h0;
  localparam logic [1:0] SF_GRP_B = 2'h1;
  localparam logic [1:0] SF_GRP_C = 2'h2;
  localparam logic [1:0] SF_GRP_D = 2'h3;
  localparam logic [11:0] SD_ERR_UNSIGNED = 12'h000;
  localparam logic [11:0] SD_ERR_SIGNED = 12'h800;
  localparam logic [7:0] CRC_POLY = 8'h2F;
  localparam logic [7:0] CRC_SEED = 8'hFF;
  // Response kinds
  typedef enum logic [1:0] {
    SESR_RSP_REG = 2'h0,
    SESR_RSP_SD = 2'h1,
    SESR_RSP_SD_NODATA = 2'h3
  } sesr_rsp_t;
endpackage : sesr_pkg

// >>> verilog/sesr_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a level, not a pulse
// Notes: first stage is read only by the second
module sesr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two stages, reset to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sesr_sync

// >>> verilog/sesr_top.sv
// Purpose: builds the error response frame of the SPI slave
// Assumes: command decode and CRC check sit elsewhere
// Notes: link side on sclk; decision on clk; the frame word is
//        loaded once per snapshot and read quasi-static on sclk
module sesr_top
  import sesr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  output logic miso_o,
  output logic miso_oe,
  input wire logic alt_status_en,
  input wire logic [NUM_SRC-1:0] fault_src,
  input wire logic supply_fault_suppress,
  input wire logic supply_timer_done,
  input wire logic data_signed,
  input wire sesr_pkg::sesr_rsp_t rsp_kind,
  input wire logic [3:0] cmd_echo,
  input wire logic [11:0] sensor_data,
  input wire logic [15:0] reg_data,
  output logic [31:0] frame_q,
  output logic frame_err_q,
  output logic [3:0] err_pri_q,
  output logic [1:0] basic_status_field_q,
  output logic [1:0] detailed_status_field_q,
  output logic periodic_disable_q,
  output logic frame_done_q
);
  import sesr_pkg::*;

  // ------------------------------------------------------------
  // Chip-select edge into the core clock
  // ------------------------------------------------------------
  logic sel_s;
  logic sel_s_q;
  logic [NUM_SRC-1:0] fault_s;
  logic [2:0] misc_s;

  // Chip select is a pin; synced active high so reset matches idle
  sesr_sync #(.W(1)) u_cs_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(~cs_n),
    .q(sel_s)
  );

  // Fault and config levels may come from slow domains
  sesr_sync #(.W(NUM_SRC)) u_flt_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(fault_src),
    .q(fault_s)
  );

  sesr_sync #(.W(3)) u_misc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({alt_status_en, supply_fault_suppress, supply_timer_done}),
    .q(misc_s)
  );

  logic cs_rise;
  assign cs_rise = ~sel_s & sel_s_q;

  // Idle level after reset, so no false frame end follows reset
  always_ff @(posedge clk) begin
    if (!rst_n) sel_s_q <= 1'b0;
    else sel_s_q <= sel_s;
  end

  // ------------------------------------------------------------
  // Priority selection
  // ------------------------------------------------------------
  logic [3:0] pri_d;
  logic any_fault;

  // Lowest number wins; index 0 is priority 1
  always_comb begin
    pri_d = 4'h0;
    any_fault = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (fault_s[i]) begin
        pri_d = 4'(i + 1);
        any_fault = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Status snapshot at chip-select release
  // ------------------------------------------------------------
  logic [3:0] snap_pri_q;
  logic snap_fault_q;
  logic [2:0] load_dly_q;

  // Captured at frame end, used for the next frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_pri_q <= 4'h0;
      snap_fault_q <= 1'b0;
    end else if (cs_rise) begin
      snap_pri_q <= pri_d;
      snap_fault_q <= any_fault;
    end
  end

  // ------------------------------------------------------------
  // Error code persistence
  // ------------------------------------------------------------
  // Error code stands a full frame: the word is loaded once per
  // snapshot and shifted out over the whole next transfer
  logic pcm_dis_q;

  // Supply error without suppression turns periodic mode off until reset
  always_ff @(posedge clk) begin
    if (!rst_n) pcm_dis_q <= 1'b0;
    else if (cs_rise && pri_d == 4'(PRI_SUPPLY + 1) && !misc_s[1])
      pcm_dis_q <= 1'b1;
  end

  // ------------------------------------------------------------
  // Field mapping
  // ------------------------------------------------------------
  logic [1:0] sf_d;
  logic echo_ok;
  logic sd_real;
  logic sd_zero;

  always_comb begin
    sf_d = SF_GRP_D;
    echo_ok = 1'b0;
    sd_real = 1'b0;
    sd_zero = 1'b0;
    if (!snap_fault_q) begin
      echo_ok = 1'b1;
      sd_real = 1'b1;
    end else if (snap_pri_q >= 4'(PRI_TEMP + 1)) begin
      sf_d = SF_GRP_A;
      echo_ok = 1'b1;
      sd_real = 1'b1;
    end else if (snap_pri_q >= 4'(PRI_FOTP + 1)) begin
      // Factory memory fault shares the group of user memory
      sf_d = SF_GRP_B;
    end else if (snap_pri_q == 4'(PRI_TEST + 1)) begin
      sf_d = SF_GRP_C;
      sd_zero = 1'b1;
    end else if (snap_pri_q == 4'(PRI_SUPPLY + 1)) begin
      sf_d = SF_GRP_C;
      // Zeros until timer ends; suppression keeps zeros after
      sd_zero = !misc_s[0] || misc_s[1];
    end else begin
      sf_d = SF_GRP_D;
    end
  end

  // ------------------------------------------------------------
  // Frame assembly
  // ------------------------------------------------------------
  logic [11:0] err_code;
  logic [11:0] sd_sel;
  logic [23:0] body;
  logic [7:0] crc;

  assign err_code = data_signed ? SD_ERR_SIGNED : SD_ERR_UNSIGNED;

  always_comb begin
    if (sd_real) sd_sel = sensor_data;
    else if (sd_zero) sd_sel = 12'h000;
    else sd_sel = err_code;
  end

  // Frame body without CRC; rsp_kind selects this map
  always_comb begin
    body = 24'h000000;
    unique case (rsp_kind)
      SESR_RSP_REG: begin
        body = {4'h0, ST_ERROR, 2'h0, reg_data};
      end
      SESR_RSP_SD: begin
        // Data left justified in bits 25:14, low nibble unused
        body = {echo_ok ? {cmd_echo[0], cmd_echo[3], cmd_echo[2], cmd_echo[1]} : 4'h0,
                ST_ERROR, sd_sel, 4'h0, sf_d};
      end
      SESR_RSP_SD_NODATA: begin
        body = {4'h0, ST_ERROR, 16'h0000, sf_d};
      end
      default: body = 24'h000000;
    endcase
  end

  // CRC over the upper 24 bits, MSB first
  always_comb begin
    crc = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      if (crc[7] ^ body[i]) crc = {crc[6:0], 1'b0} ^ CRC_POLY;
      else crc = {crc[6:0], 1'b0};
    end
  end

  // Registered outputs, all but periodic_disable_q loaded once after each snapshot so they
  // stand unchanged through the whole next frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_q <= 32'h00000000;
      frame_err_q <= 1'b0;
      err_pri_q <= 4'h0;
      basic_status_field_q <= 2'h0;
      detailed_status_field_q <= 2'h0;
      periodic_disable_q <= 1'b0;
    end else begin
      periodic_disable_q <= pcm_dis_q;
      if (load_dly_q[0]) begin
        frame_q <= {body, crc};
        frame_err_q <= snap_fault_q && misc_s[2];
        err_pri_q <= snap_pri_q;
        basic_status_field_q <= snap_fault_q ? ST_ERROR : 2'h0;
        detailed_status_field_q <= sf_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Snapshot pipeline and done pulse
  // ------------------------------------------------------------
  // Done pulse comes once the outputs have been loaded
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_dly_q <= 3'h0;
      frame_done_q <= 1'b0;
    end else begin
      load_dly_q <= {load_dly_q[1:0], cs_rise};
      frame_done_q <= load_dly_q[2];
    end
  end

  // ------------------------------------------------------------
  // Link domain: shift out on sclk falling edge
  // ------------------------------------------------------------
  // Frame word changes only four clk after select rises, and the
  // host keeps select high 8 clk at least, so the word is a
  // quasi-static bus for the whole frame on the sclk side
  logic tgl_seen_q;
  logic [31:0] shift_q;

  // Load at first edge of a frame, shift on later edges
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shift_q <= 32'h00000000;
      tgl_seen_q <= 1'b0;
    end else if (!tgl_seen_q) begin
      shift_q <= {frame_q[30:0], 1'b0};
      tgl_seen_q <= 1'b1;
    end else begin
      shift_q <= {shift_q[30:0], 1'b0};
    end
  end

  // Bit 31 is presented as soon as select falls
  always_comb begin
    miso_o = tgl_seen_q ? shift_q[31] : frame_q[31];
    miso_oe = ~cs_n;
  end
endmodule : sesr_top

// >>> test/sesr_spi_host.sv
// Purpose: SPI host model driving frames into the formatter
// Assumes: mode 0, sclk low at both select edges
// Notes: link clock of 32 ns runs only inside a frame
module sesr_spi_host (
  output logic sclk,
  output logic cs_n,
  input wire logic miso_o,
  input wire logic miso_oe
);
  timeunit 1ns / 100ps;
  // Idle: select high, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // Exactly 32 rising edges per frame keeps framing clean
  task automatic xfer(output logic [31:0] w);
    w = '0;
    #3;
    cs_n = 1'b0;
    #16;
    repeat (32) begin
      sclk = 1'b1;
      // Undriven line reads as inverse of last bit, never a lucky match
      w = {w[30:0], miso_oe ? miso_o : ~w[0]};
      #16;
      sclk = 1'b0;
      #16;
    end
    cs_n = 1'b1;
  endtask : xfer
endmodule : sesr_spi_host

// >>> test/sesr_monitor.sv
// Purpose: port assertions for the error response formatter
// Assumes: inputs held steady until frame_done_q
// Notes: clk domain only
module sesr_monitor
  import sesr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire sesr_pkg::sesr_rsp_t rsp_kind,
  input wire logic [31:0] frame_q,
  input wire logic frame_err_q,
  input wire logic [3:0] err_pri_q,
  input wire logic [1:0] detailed_status_field_q,
  input wire logic periodic_disable_q,
  input wire logic frame_done_q
);
  timeunit 1ns / 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------
  // Status coding
  // ------------------
  a_sf_upper: assert property (frame_err_q && err_pri_q > 4'h8 |-> detailed_status_field_q == SF_GRP_A)
    else $error("detailed status wrong, high priority");
  a_sf_memory: assert property (frame_err_q && err_pri_q inside {[4'h6:4'h8]}
    |-> detailed_status_field_q == SF_GRP_B) else $error("detailed status wrong, memory");
  a_sf_middle: assert property (frame_err_q && err_pri_q inside {4'h4, 4'h5}
    |-> detailed_status_field_q == SF_GRP_C) else $error("detailed status wrong, test or supply");
  a_sf_lower: assert property (frame_err_q && err_pri_q inside {[4'h1:4'h3]}
    |-> detailed_status_field_q == SF_GRP_D) else $error("detailed status wrong, low priority");
  // ------------------
  // Frame contents and timing
  // ------------------
  a_echo_zero: assert property (frame_done_q && frame_err_q && err_pri_q < 4'h9 |-> frame_q[31:28] == 4'h0)
    else $error("command echo not zero");
  a_reg_head: assert property (frame_done_q && frame_err_q && rsp_kind == SESR_RSP_REG
    |-> frame_q[31:24] == 8'h0C) else $error("register error head wrong");
  a_done_once: assert property (frame_done_q |=> !frame_done_q)
    else $error("frame done longer than one cycle");
  a_done_timely: assert property ($rose(cs_n) |-> ##[2:12] frame_done_q)
    else $error("frame done missing after select release");
  a_pcm_sticky: assert property (periodic_disable_q |=> periodic_disable_q)
    else $error("periodic disable dropped");
  // Main scenarios
  c_spi_fault: cover property (frame_done_q && err_pri_q == 4'h1);
  c_pcm_off: cover property ($rose(periodic_disable_q));
  c_reg_err: cover property (frame_done_q && frame_err_q && rsp_kind == SESR_RSP_REG);
endmodule : sesr_monitor
bind sesr_top sesr_monitor i_sesr_monitor (.clk, .rst_n, .cs_n, .rsp_kind, .frame_q, .frame_err_q,
  .err_pri_q, .detailed_status_field_q, .periodic_disable_q, .frame_done_q);

// >>> test/test_sesr_top.sv
// Purpose: self-checking bench for the error response formatter
// Assumes: one fault pattern per frame, inputs held until checked
// Notes: each frame but the last is also checked as shifted out on the next one
module test_sesr_top
  import sesr_pkg::*;
;
  timeunit 1ns / 100ps;
  logic clk = 1'b0, rst_n = 1'b0, alt_status_en = 1'b1, sclk, cs_n, miso_o, miso_oe;
  logic [NUM_SRC-1:0] fault_src = '0;
  logic supply_fault_suppress = 1'b0, supply_timer_done = 1'b0, data_signed = 1'b0;
  sesr_rsp_t rsp_kind = SESR_RSP_SD, e_kind;
  logic [3:0] cmd_echo = 4'hD, err_pri_q, e_cmd;
  logic [11:0] sensor_data = 12'h5C3;
  logic [15:0] reg_data = 16'hA55A, e_data;
  logic [31:0] frame_q;
  logic [1:0] basic_status_field_q, detailed_status_field_q, e_sf;
  logic frame_err_q, periodic_disable_q, frame_done_q, e_zr, pd = 1'b0, have_prev = 1'b0;
  int failures = 0, checks_done = 0;
  sesr_top i_sesr_top (.clk, .rst_n, .sclk, .cs_n, .miso_o, .miso_oe, .alt_status_en, .fault_src,
    .supply_fault_suppress, .supply_timer_done, .data_signed, .rsp_kind, .cmd_echo, .sensor_data,
    .reg_data, .frame_q, .frame_err_q, .err_pri_q, .basic_status_field_q, .detailed_status_field_q,
    .periodic_disable_q, .frame_done_q);
  sesr_spi_host i_sesr_spi_host (.sclk, .cs_n, .miso_o, .miso_oe);
  // Core clock, 4 ns
  always #2 clk = ~clk;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Field compare against the expectation of the last snapshot
  task automatic check_word(input logic [31:0] w);
    check("command echo", w[31:28], e_cmd);
    if (e_kind == SESR_RSP_REG) check("register frame", w[27:8], {4'hC, e_data});
    else begin
      check("sensor field", w[SD_LSB+:12], e_data[11:0]);
      if (!e_zr) check("frame status", {w[27:26], w[SF_LSB+:2]}, {ST_ERROR, e_sf});
    end
  endtask : check_word
  task automatic run(input logic [10:0] f, input sesr_rsp_t k, input logic sup, tmr, sgn);
    logic [31:0] w;
    int p;
    int n;
    fault_src = f;
    rsp_kind = k;
    supply_fault_suppress = sup;
    supply_timer_done = tmr;
    data_signed = sgn;
    p = 0;
    for (int i = 10; i >= 0; i--)
      if (f[i]) p = i + 1;
    i_sesr_spi_host.xfer(w);
    if (have_prev) check_word(w);
    e_kind = k;
    e_zr = (p == 5) || (p == 4 && !(tmr && !sup));
    e_cmd = (p >= 9 && k == SESR_RSP_SD) ? {cmd_echo[0], cmd_echo[3:1]} : 4'h0;
    e_sf = (p >= 9) ? SF_GRP_A : (p >= 6) ? SF_GRP_B : (p >= 4) ? SF_GRP_C : SF_GRP_D;
    e_data = (k == SESR_RSP_REG) ? reg_data : (k != SESR_RSP_SD || e_zr) ? 16'h0 :
      (p >= 9) ? {4'h0, sensor_data} : {4'h0, sgn ? SD_ERR_SIGNED : SD_ERR_UNSIGNED};
    pd = pd | (p == 4 && tmr && !sup);
    // Bounded wait for the snapshot to land
    n = 0;
    while (frame_done_q !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) check("frame done", 1'b0, 1'b1);
    check("frame error", frame_err_q, alt_status_en);
    if (alt_status_en) begin
      check_word(frame_q);
      check("priority", err_pri_q, p);
      check("status", {basic_status_field_q, detailed_status_field_q}, {ST_ERROR, e_sf});
      if (p != 4 || pd) check("periodic disable", periodic_disable_q, pd);
    end
    have_prev = alt_status_en;
    $display("case done: priority %0d kind %0d", p, k);
    repeat (6) @(posedge clk);
    #1;
  endtask : run
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int p = 1; p <= 11; p++) begin
      run(11'h1 << (p - 1), SESR_RSP_SD, 1'b0, 1'b1, p[0]);
    end
    run(11'h008, SESR_RSP_SD, 1'b0, 1'b0, 1'b0);
    run(11'h008, SESR_RSP_SD, 1'b1, 1'b1, 1'b1);
    run(11'h484, SESR_RSP_SD, 1'b0, 1'b1, 1'b1);
    run(11'h001, SESR_RSP_REG, 1'b0, 1'b1, 1'b0);
    run(11'h200, SESR_RSP_SD_NODATA, 1'b0, 1'b1, 1'b1);
    alt_status_en = 1'b0;
    run(11'h001, SESR_RSP_SD, 1'b0, 1'b1, 1'b0);
    finish_test();
  end
  // Watchdog, well past the roughly 19 us the cases need
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule : test_sesr_top
